//--- common/rcr_pkg.sv
/*
 * Constants for the regulator control register bank: offsets, reset
 * values, field positions, reference code limits and ramp timing.
 * Assumes a 20 MHz internal logic clock.
 */
package rcr_pkg;
   // Register offsets
   localparam logic [7:0] RCR_OFS_REF  = 8'h13;
   localparam logic [7:0] RCR_OFS_CTRL = 8'h14;
   localparam logic [7:0] RCR_OFS_CFG  = 8'h15;
   // Reset values
   localparam logic [7:0] RCR_RST_REF  = 8'h44;
   localparam logic [7:0] RCR_RST_CTRL = 8'h0C;
   localparam logic [7:0] RCR_RST_CFG  = 8'h00;
   localparam logic [7:0] RCR_RD_NONE  = 8'h00;
   // Field positions
   localparam int RCR_FORCED_PULSE_WIDTH_ENABLE_BIT    = 5;
   localparam int RCR_RAMP_LSB    = 0;
   localparam int RCR_FASTEXT_BIT = 0;
   // Reference code limits and voltage mapping
   localparam logic [7:0]  RCR_CODE_MIN = 8'h3D;
   localparam logic [7:0]  RCR_CODE_MAX = 8'hCC;
   localparam int          RCR_STEP_UV  = 4900;
   localparam logic [19:0] RCR_BASE_UV  = 20'h48FF8;   // 299000 uV
   localparam logic [19:0] RCR_TOP_UV   = 20'hF4240;   // 1000000 uV
   // Clock and ramp timing; rate is NUM/DEN mV/us, step time in ns = uV * DEN / NUM
   localparam int RCR_CLK_NS = 50;
   localparam int RCR_R00_LO_NUM = 7;
   localparam int RCR_R00_LO_DEN = 6;
   localparam int RCR_R00_HI_NUM = 4;
   localparam int RCR_R00_HI_DEN = 3;
   localparam int RCR_R01_NUM    = 2;
   localparam int RCR_R01_DEN    = 3;
   localparam int RCR_R10_NUM    = 1;
   localparam int RCR_R10_DEN    = 3;
   localparam int RCR_R11_LO_NUM = 1;
   localparam int RCR_R11_LO_DEN = 6;
   localparam int RCR_R11_HI_NUM = 17;
   localparam int RCR_R11_HI_DEN = 75;

   // Cycles per reference step, rounded up so the rate is never exceeded
   function automatic int rcr_step_cycles(input int num, input int den);
      int ns_x;
      ns_x = RCR_STEP_UV * den;
      return (ns_x + num * RCR_CLK_NS - 1) / (num * RCR_CLK_NS);
   endfunction

   localparam int RCR_CYC_00_LO = rcr_step_cycles(RCR_R00_LO_NUM, RCR_R00_LO_DEN);
   localparam int RCR_CYC_00_HI = rcr_step_cycles(RCR_R00_HI_NUM, RCR_R00_HI_DEN);
   localparam int RCR_CYC_01    = rcr_step_cycles(RCR_R01_NUM, RCR_R01_DEN);
   localparam int RCR_CYC_10    = rcr_step_cycles(RCR_R10_NUM, RCR_R10_DEN);
   localparam int RCR_CYC_11_LO = rcr_step_cycles(RCR_R11_LO_NUM, RCR_R11_LO_DEN);
   localparam int RCR_CYC_11_HI = rcr_step_cycles(RCR_R11_HI_NUM, RCR_R11_HI_DEN);
   localparam int RCR_CNT_W     = 10;

   typedef enum logic [1:0] {
      RCR_RAMP_FAST,
      RCR_RAMP_MID,
      RCR_RAMP_SLOW,
      RCR_RAMP_SLOWEST
   } rcr_ramp_t;

   // Clamp a written code into the linear range
   function automatic logic [7:0] rcr_clamp(input logic [7:0] code);
      if (code < RCR_CODE_MIN) begin
         return RCR_CODE_MIN;
      end else if (code > RCR_CODE_MAX) begin
         return RCR_CODE_MAX;
      end
      return code;
   endfunction
endpackage

//--- core/rcr_ramp.sv
/*
 * Reference stepper: moves the present reference code one step at a
 * time toward the clamped target, one step per selected step period.
 * Assumes the target is already clamped and the clear is synchronous.
 */
`timescale 1ns/1ps
module rcr_ramp
   import rcr_pkg::*;
(
   // Clock and clears
   input  wire logic                  clk_i,
   input  wire logic                  clear_i,
   // Target and step period
   input  wire logic [7:0]            target_i,
   input  wire logic [RCR_CNT_W-1:0]  period_i,
   // Present reference
   output logic      [7:0]            level_o,
   output logic                       busy_o
);
   logic [RCR_CNT_W-1:0] count;
   wire                  at_target = (level_o == target_i);
   wire                  step_due  = (count >= period_i - 1'b1);
   wire                  going_up  = (target_i > level_o);

   // Step timer restarts whenever the reference is settled
   always_ff @(posedge clk_i) begin
      if (clear_i || at_target || step_due) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // One code per period, never a jump to the target
   always_ff @(posedge clk_i) begin
      if (clear_i) begin
         level_o <= rcr_clamp(RCR_RST_REF);
         busy_o  <= 1'b0;
      end else begin
         busy_o <= !at_target;
         if (!at_target && step_due) begin
            level_o <= going_up ? level_o + 8'h01 : level_o - 8'h01;
         end
      end
   end
endmodule

//--- core/rcr_regs.sv
/*
 * Regulator control register bank: reference code, mode and ramp
 * control, serial interface configuration, plus the ramped reference.
 * Assumes the serial interface decoder gives single-cycle write and
 * read strobes with a byte address, and that the frequency select
 * comes from the neighbouring control register.
 */
`timescale 1ns/1ps
module rcr_regs
   import rcr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Register clear conditions
   input  wire logic        io_supply_valid_i,
   input  wire logic        input_lockout_i,
   input  wire logic        enable_i,
   // Register access port from the serial interface
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o,
   // Neighbouring switching frequency select
   input  wire logic [1:0]  switching_frequency_select_i,
   // Control outputs
   output logic             forced_pulse_width_enable_o,
   output logic             fast_mode_extension_enable_o,
   output logic [7:0]       reference_code_o,
   output logic [19:0]      reference_uv_o,
   output logic             dynamic_voltage_scaling_o
);
   logic [7:0]           output_reference_code;
   logic [7:0]           mode_and_ramp_control;
   logic [7:0]           serial_interface_config;
   logic [7:0]           next_rdata;
   logic [RCR_CNT_W-1:0] step_period;
   logic [7:0]           ramp_level;
   logic                 ramp_busy;

   // Any loss of supply, lockout or low enable clears everything
   wire clear_all = rst_i || !io_supply_valid_i || input_lockout_i || !enable_i;

   // Address decode
   wire hit_ref  = (addr_i == RCR_OFS_REF);
   wire hit_ctrl = (addr_i == RCR_OFS_CTRL);
   wire hit_cfg  = (addr_i == RCR_OFS_CFG);

   // Frequency 10/11 selects the faster table column
   wire        switching_frequency_select_high = switching_frequency_select_i[1];
   rcr_ramp_t  ramp_sel;
   assign ramp_sel = rcr_ramp_t'(mode_and_ramp_control[RCR_RAMP_LSB +: 2]);

   // Step period per ramp select and frequency
   always_comb begin
      unique case (ramp_sel)
         RCR_RAMP_FAST:
            step_period = switching_frequency_select_high ? RCR_CNT_W'(RCR_CYC_00_HI) : RCR_CNT_W'(RCR_CYC_00_LO);
         RCR_RAMP_MID:
            step_period = RCR_CNT_W'(RCR_CYC_01);
         RCR_RAMP_SLOW:
            step_period = RCR_CNT_W'(RCR_CYC_10);
         RCR_RAMP_SLOWEST:
            step_period = switching_frequency_select_high ? RCR_CNT_W'(RCR_CYC_11_HI) : RCR_CNT_W'(RCR_CYC_11_LO);
      endcase
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      if (hit_ref) begin
         next_rdata = output_reference_code;
      end else if (hit_ctrl) begin
         next_rdata = mode_and_ramp_control;
      end else if (hit_cfg) begin
         next_rdata = serial_interface_config;
      end else begin
         next_rdata = RCR_RD_NONE;
      end
   end

   // Register writes
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         output_reference_code   <= RCR_RST_REF;
         mode_and_ramp_control   <= RCR_RST_CTRL;
         serial_interface_config <= RCR_RST_CFG;
      end else if (wr_en_i) begin
         if (hit_ref) begin
            output_reference_code <= wdata_i;
         end
         if (hit_ctrl) begin
            mode_and_ramp_control <= wdata_i;
         end
         if (hit_cfg) begin
            serial_interface_config <= wdata_i;
         end
      end
   end

   // Read data held until the next read or a clear
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         rdata_o <= RCR_RD_NONE;
      end else if (rd_en_i) begin
         rdata_o <= next_rdata;
      end
   end

   // Mode bits registered straight to the pins; one cycle behind the store
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         forced_pulse_width_enable_o  <= 1'b0;
         fast_mode_extension_enable_o <= 1'b0;
      end else begin
         forced_pulse_width_enable_o  <= mode_and_ramp_control[RCR_FORCED_PULSE_WIDTH_ENABLE_BIT];
         fast_mode_extension_enable_o <= serial_interface_config[RCR_FASTEXT_BIT];
      end
   end

   // Ramp toward the clamped target
   rcr_ramp u_ramp (
      .clk_i    (clk_i),
      .clear_i  (clear_all),
      .target_i (rcr_clamp(output_reference_code)),
      .period_i (step_period),
      .level_o  (ramp_level),
      .busy_o   (ramp_busy)
   );

   // Code to microvolts on the linear segment; top code reports a full 1.000 V
   // rather than the 999.7 mV that the straight line would give
   function automatic logic [19:0] rcr_code_uv(input logic [7:0] code);
      logic [7:0] rel;
      rel = code - RCR_CODE_MIN;
      if (code == RCR_CODE_MAX) begin
         return RCR_TOP_UV;
      end
      return RCR_BASE_UV + 20'(RCR_STEP_UV * int'(rel));
   endfunction

   // Volts always agree with the code shown, during a clear as well
   wire [19:0] level_uv = rcr_code_uv(ramp_level);
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         reference_code_o          <= rcr_clamp(RCR_RST_REF);
         reference_uv_o            <= rcr_code_uv(rcr_clamp(RCR_RST_REF));
         dynamic_voltage_scaling_o <= 1'b0;
      end else begin
         reference_code_o          <= ramp_level;
         reference_uv_o            <= level_uv;
         dynamic_voltage_scaling_o <= ramp_busy;
      end
   end
endmodule

//--- verif/rcr_host.sv
/* Serial host stand-in: turns bench calls into one-cycle register strobes.
   Assumes one access at a time, launched on rising edges of clk_i. */
`timescale 1ns/1ps
module rcr_host (
   // Clock
   input  wire logic       clk_i,
   // Register strobes toward the bank
   output logic            wr_en_o,
   output logic            rd_en_o,
   output logic [7:0]      addr_o,
   output logic [7:0]      wdata_o,
   input  wire logic [7:0] rdata_i
);
   // Idle bus at time zero
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o  = 8'h00;
      wdata_o = 8'h00;
   end
   // Write strobe; released data is inverted so stale bytes never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      addr_o  <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      wdata_o <= ~d;
   endtask
   // Read strobe; data is taken once the answering edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      addr_o  <= a;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule

//--- verif/rcr_monitor.sv
/* Port checker for the regulator control register bank.
   Assumes a single clock domain; bound to every bank instance. */
`timescale 1ns/1ps
module rcr_monitor (
   // Clock, reset and clear sources
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        io_supply_valid_i,
   input wire logic        input_lockout_i,
   input wire logic        enable_i,
   // Register port
   input wire logic        wr_en_i,
   input wire logic        rd_en_i,
   input wire logic [7:0]  addr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic [7:0]  rdata_o,
   input wire logic [1:0]  switching_frequency_select_i,
   // Control outputs
   input wire logic        forced_pulse_width_enable_o,
   input wire logic        fast_mode_extension_enable_o,
   input wire logic [7:0]  reference_code_o,
   input wire logic [19:0] reference_uv_o,
   input wire logic        dynamic_voltage_scaling_o
);
   // Every clear source acts alike
   wire clr = rst_i | !io_supply_valid_i | input_lockout_i | !enable_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   clear_outputs_a: assert property (clr ##1 clr |=>
      !forced_pulse_width_enable_o && !fast_mode_extension_enable_o && reference_code_o == 8'h44)
      else $error("outputs not cleared");
   forced_pulse_width_enable_follow_a: assert property ((wr_en_i && addr_i == 8'h14 && !clr) ##1 !clr |=>
      forced_pulse_width_enable_o == $past(wdata_i[5], 2)) else $error("forced_pulse_width_enable wrong");
   fastext_follow_a: assert property ((wr_en_i && addr_i == 8'h15 && !clr) ##1 !clr |=>
      fast_mode_extension_enable_o == $past(wdata_i[0], 2)) else $error("fast ext wrong");
   read_back_a: assert property ((wr_en_i && addr_i == 8'h14 && !clr) ##1 (!clr && !wr_en_i) ##1
      (rd_en_i && addr_i == 8'h14 && !clr) |=> rdata_o == $past(wdata_i, 3)) else $error("readback");
   ref_range_a: assert property (reference_code_o >= 8'h3D && reference_code_o <= 8'hCC)
      else $error("reference out of range");
   ref_step_a: assert property (!clr && !$past(clr) |->
      8'(reference_code_o - $past(reference_code_o)) inside {8'h00, 8'h01, 8'hFF})
      else $error("reference jumped");
   ref_spacing_a: assert property (!clr && !$past(clr) && $changed(reference_code_o) |=>
      (clr || $past(clr) || $stable(reference_code_o)) [*8]) else $error("steps too close");
   dvs_moving_a: assert property (!clr && !$past(clr) && $changed(reference_code_o) |->
      $past(dynamic_voltage_scaling_o)) else $error("moved while idle");
endmodule
bind rcr_regs rcr_monitor mon_u (.*);

//--- verif/tb.sv
/* Self-checking bench for the register bank: reset, access, clears, ramps.
   Assumes the host model in rcr_host and the bound port checker. */
`timescale 1ns/1ps
module tb;
   import rcr_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, vio_ok = 1'b1, lockout = 1'b0, en = 1'b1;
   logic [1:0] switching_frequency_select = 2'b00;
   logic wr_en, rd_en, forced_pulse_width_enable, fext, dynamic_voltage_scaling;
   logic [7:0] addr, wdata, rdata, ref_code, rv;
   logic [19:0] ref_uv;
   int failures, checks, c;
   int exp_cyc [8] = '{84, 147, 294, 588, 74, 147, 294, 433};
   rcr_host host_u (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
      .wdata_o(wdata), .rdata_i(rdata));
   rcr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .io_supply_valid_i(vio_ok),
      .input_lockout_i(lockout), .enable_i(en), .wr_en_i(wr_en), .rd_en_i(rd_en),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .switching_frequency_select_i(switching_frequency_select),
      .forced_pulse_width_enable_o(forced_pulse_width_enable), .fast_mode_extension_enable_o(fext),
      .reference_code_o(ref_code), .reference_uv_o(ref_uv), .dynamic_voltage_scaling_o(dynamic_voltage_scaling));
   // 20 MHz clock
   initial forever #25 clk_i = ~clk_i;
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      host_u.rd(a, rv);
      chk(rv, exp);
   endtask
   // Bounded wait for the reference output to leave (or reach) a code
   task automatic wait_ref(input logic [7:0] v, input logic leave);
      c = 0;
      while ((ref_code === v) == leave && c < 20000) begin
         @(posedge clk_i);
         #1 c++;
      end
      if (c >= 20000) begin
         failures++;
         test_done();
      end
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(8'h13, 8'h44);
      chk(ref_uv, 20'h515F4);
      rdc(8'h14, 8'h0C);
      rdc(8'h15, 8'h00);
      host_u.wr(8'h16, 8'hFF);
      rdc(8'h16, 8'h00);
      $display("reset values done");
      for (int k = 0; k < 3; k++) begin
         host_u.wr(8'h14, 8'h20);
         host_u.wr(8'h13, 8'h50);
         rdc(8'h14, 8'h20);
         host_u.wr(8'h15, 8'h01);
         rdc(8'h15, 8'h01);
         chk({forced_pulse_width_enable, fext, dynamic_voltage_scaling}, 3'b111);
         @(posedge clk_i);
         vio_ok <= (k != 0);
         lockout <= (k == 1);
         en <= (k != 2);
         repeat (2) @(posedge clk_i);
         {vio_ok, lockout, en} <= 3'b101;
         rdc(8'h14, 8'h0C);
         rdc(8'h15, 8'h00);
         rdc(8'h13, 8'h44);
         chk({forced_pulse_width_enable, fext, dynamic_voltage_scaling, ref_code}, 11'h044);
      end
      $display("clear sources done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         switching_frequency_select <= {i[2], i[0]};
         host_u.wr(8'h14, 8'h0C | 8'(i[1:0]));
         rv = ref_code;
         host_u.wr(8'h13, rv + 8'h01);
         wait_ref(rv, 1'b1);
         chk(c >= exp_cyc[i] && c <= exp_cyc[i] + 3, 1'b1);
      end
      $display("ramp rates done");
      host_u.wr(8'h14, 8'h0C);
      host_u.wr(8'h13, 8'hFF);
      rdc(8'h13, 8'hFF);
      wait_ref(8'hCC, 1'b0);
      repeat (2) @(posedge clk_i);
      chk(ref_uv, 20'hF4240);
      host_u.wr(8'h13, 8'h00);
      wait_ref(8'h3D, 1'b0);
      repeat (2) @(posedge clk_i);
      chk({dynamic_voltage_scaling, ref_uv}, 21'h048FF8);
      $display("clamp and ramp done");
      test_done();
   end
endmodule
